// ### uvdr_defs.vh
/*
  Constants for the undervoltage detect and reset block: control register
  layout, reset values, level codes and timing.
  Assumes it is included by bare name from the design file.
*/
`ifndef UVDR_DEFS_VH
`define UVDR_DEFS_VH

// Register addresses on the plain register port
`define UVDR_ADDR_W        2
`define UVDR_ADDR_CTRL     2'h0
`define UVDR_ADDR_MASK     2'h1
`define UVDR_ADDR_STAT     2'h2

// Control register fields
`define UVDR_BIT_IRQ_FLAG  6
`define UVDR_BIT_OK_STATE  5
`define UVDR_BIT_IRQ_EN    4
`define UVDR_BIT_WAKE_EN   3
`define UVDR_BIT_DET_ON    2
`define UVDR_LVL_HI        1
`define UVDR_LVL_LO        0

// Status / mask register fields
`define UVDR_EV_DETECT     0
`define UVDR_EV_FREEZE     1
`define UVDR_EV_RESET      2
`define UVDR_EV_W          3

// Reset values
`define UVDR_LVL_RST       2'h3
`define UVDR_EV_RST        3'h0

// Option code meaning power-on reset only
`define UVDR_OPT_POR_ONLY  2'h3

// Dip duration before full reset, in ns, and clock period in ns
`define UVDR_DIP_NS        80000
`define UVDR_CLK_NS        20
`define UVDR_DIP_CYC       (`UVDR_DIP_NS / `UVDR_CLK_NS)
`define UVDR_CNT_W         13
`define UVDR_SYS_RST_CYC   16

`endif

// ### uvdr_low_voltage_detect_reset.v
/*
  Undervoltage detector and brownout reset logic for a small controller core.
  Assumes analog comparators outside give one flag per detect level and one
  per reset level (high = supply at or below), and that the core reports
  sleep/idle as a level and global interrupt instructions as one-cycle pulses.
*/
// The plain strobed port and the register offsets are this design's own decisions.
// Contract
// [RULE1] Two-bit programmed option picks reset level; 11 means power-on reset only.
// [RULE2] One 8-bit control register: flag, state, irq enable, wake, enable, level.
// [RULE3] State bit read-only: 0 at or below detect level, 1 above.
// [RULE4] Level select 11/10/01/00 picks 2.2/3.3/4.0/4.5 V detect points.
// [RULE5] Detector off makes state bit read 1 always.
// [RULE6] Bit 2 turns detection off (0) or on (1).
// [RULE7] Flag stays 0 above detect point, set once supply falls below.
// [RULE8] Flag stays set until software writes 0 or system reset.
// [RULE9] System reset clears the interrupt flag.
// [RULE10] Interrupt requested only with flag set and irq enable high.
// [RULE11] Global enable/disable instructions switch global interrupt acceptance.
// [RULE12] Flag set in sleep or idle wakes device only if wake enable set.
// [RULE13] Detector keeps running and updating flag during sleep.
// [RULE14] Dip below reset level under 80 us halts core, keeps registers.
// [RULE15] Dip below reset level over 80 us forces full system reset.
// [RULE16] Software: level, wake, irq enable, global enable, detector on, wait, clear.
// [RULE17] Comparator outputs synchronized before state bit, flag or timer.
`include "uvdr_defs.vh"
module uvdr_low_voltage_detect_reset #(
  parameter DIP_CYC = `UVDR_DIP_CYC,
  parameter SYS_RST_CYC = `UVDR_SYS_RST_CYC
) (
  input  wire                    core_clk_i,      // 50 MHz core clock
  input  wire                    nrst_i,          // Async reset, active low
  input  wire [1:0]              brownout_opt_i,  // Programmed reset option
  input  wire [3:0]              det_cmp_i,       // Below detect level, by code
  input  wire [2:0]              rst_cmp_i,       // Below reset level, by code
  input  wire                    sleep_i,         // Core in sleep or idle
  input  wire                    global_irq_on_instr_i,  // Enable pulse
  input  wire                    global_irq_off_instr_i, // Disable pulse
  input  wire [`UVDR_ADDR_W-1:0] addr_i,          // Register address
  input  wire [7:0]              wdata_i,         // Write data
  input  wire                    wr_i,            // Write strobe
  input  wire                    rd_i,            // Read strobe
  output reg  [7:0]              rdata_o,         // Read data, next cycle
  output wire                    irq_req_o,       // Interrupt to core vector
  output wire                    wake_o,          // Wake from sleep or idle
  output wire                    core_halt_o,     // Freeze core execution
  output reg                     sys_rst_n_o,     // System reset, active low
  output wire                    irq_o            // Event interrupt level
);

  // Three-stage synchronizers on comparator inputs
  reg  [3:0] det_s1_reg, det_s2_reg, det_s3_reg;
  reg  [2:0] rst_s1_reg, rst_s2_reg, rst_s3_reg;
  reg  [3:0] det_q_reg;
  reg  [2:0] rst_q_reg;
  reg  [1:0] opt_reg;
  reg        opt_taken_reg;
  reg  [1:0] level_reg;
  reg        det_on_reg;
  reg        wake_en_reg;
  reg        irq_en_reg;
  reg        flag_reg;
  reg        gie_reg;
  reg  [`UVDR_EV_W-1:0] stat_reg;
  reg  [`UVDR_EV_W-1:0] mask_reg;
  reg  [`UVDR_CNT_W-1:0] dip_cnt_reg;
  reg  [4:0] rst_cnt_reg;
  reg        below_det;
  reg        below_rst;
  wire       ok_state;
  wire       det_set;
  wire       dip_long;
  wire       sw_rst_n;
  wire [`UVDR_EV_W-1:0] ev;
  wire [7:0] ctrl_val;

  // Synchronizer chain; a change counts once stages two and three agree
  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      det_s1_reg <= 4'h0;
      det_s2_reg <= 4'h0;
      det_s3_reg <= 4'h0;
      rst_s1_reg <= 3'h0;
      rst_s2_reg <= 3'h0;
      rst_s3_reg <= 3'h0;
      det_q_reg  <= 4'h0;
      rst_q_reg  <= 3'h0;
    end
    else
    begin
      det_s1_reg <= det_cmp_i;  // RULE17
      det_s2_reg <= det_s1_reg;
      det_s3_reg <= det_s2_reg;
      rst_s1_reg <= rst_cmp_i;  // RULE17
      rst_s2_reg <= rst_s1_reg;
      rst_s3_reg <= rst_s2_reg;
      det_q_reg  <= (det_s2_reg & det_s3_reg) |
                    (det_q_reg & (det_s2_reg | det_s3_reg));
      rst_q_reg  <= (rst_s2_reg & rst_s3_reg) |
                    (rst_q_reg & (rst_s2_reg | rst_s3_reg));
    end
  end

  // Option captured once after reset release
  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      opt_reg       <= `UVDR_OPT_POR_ONLY;
      opt_taken_reg <= 1'b0;
    end
    else if (!opt_taken_reg)
    begin
      opt_reg       <= brownout_opt_i;
      opt_taken_reg <= 1'b1;
    end
  end

  // Detect point: index 3=2.2V, 2=3.3V, 1=4.0V, 0=4.5V
  always @*
  begin
    below_det = det_q_reg[level_reg];  // RULE4
    case (opt_reg)
      2'h2:    below_rst = rst_q_reg[0];  // RULE1
      2'h1:    below_rst = rst_q_reg[1];
      2'h0:    below_rst = rst_q_reg[2];
      default: below_rst = 1'b0;
    endcase
  end

  assign ok_state = ~(det_on_reg & below_det);  // RULE3 RULE5 RULE6
  assign det_set  = det_on_reg & below_det;     // RULE7 RULE13
  assign ctrl_val = {1'b0, flag_reg, ok_state, irq_en_reg, wake_en_reg,
                     det_on_reg, level_reg};    // RULE2

  // Dip duration counter
  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      dip_cnt_reg <= {`UVDR_CNT_W{1'b0}};
    else if (!below_rst)
      dip_cnt_reg <= {`UVDR_CNT_W{1'b0}};
    else if (!dip_long)
      dip_cnt_reg <= dip_cnt_reg + 1'b1;
  end

  assign dip_long    = (dip_cnt_reg >= DIP_CYC[`UVDR_CNT_W-1:0]);
  assign core_halt_o = below_rst & ~dip_long;  // RULE14

  // System reset pulse after long dip
  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rst_cnt_reg <= 5'h00;
    else if (dip_long)
      rst_cnt_reg <= SYS_RST_CYC[4:0];  // RULE15
    else if (rst_cnt_reg != 5'h00)
      rst_cnt_reg <= rst_cnt_reg - 5'h01;
  end

  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sys_rst_n_o <= 1'b0;
    else
      sys_rst_n_o <= ~dip_long & (rst_cnt_reg == 5'h00);
  end

  assign sw_rst_n = sys_rst_n_o;

  // Control register
  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      level_reg   <= `UVDR_LVL_RST;
      det_on_reg  <= 1'b0;
      wake_en_reg <= 1'b0;
      irq_en_reg  <= 1'b0;
      flag_reg    <= 1'b0;
      gie_reg     <= 1'b0;
    end
    else if (!sw_rst_n)
    begin
      level_reg   <= `UVDR_LVL_RST;
      det_on_reg  <= 1'b0;
      wake_en_reg <= 1'b0;
      irq_en_reg  <= 1'b0;
      flag_reg    <= 1'b0;  // RULE9
      gie_reg     <= 1'b0;
    end
    else
    begin
      if (wr_i && addr_i == `UVDR_ADDR_CTRL)
      begin
        level_reg   <= wdata_i[`UVDR_LVL_HI:`UVDR_LVL_LO];
        det_on_reg  <= wdata_i[`UVDR_BIT_DET_ON];  // RULE6
        wake_en_reg <= wdata_i[`UVDR_BIT_WAKE_EN];
        irq_en_reg  <= wdata_i[`UVDR_BIT_IRQ_EN];
      end
      // Set wins over a software clear in the same cycle
      if (det_set)
        flag_reg <= 1'b1;  // RULE7
      else if (wr_i && addr_i == `UVDR_ADDR_CTRL &&
               !wdata_i[`UVDR_BIT_IRQ_FLAG])
        flag_reg <= 1'b0;  // RULE8
      if (global_irq_on_instr_i)
        gie_reg <= 1'b1;  // RULE11
      else if (global_irq_off_instr_i)
        gie_reg <= 1'b0;  // RULE11
    end
  end

  assign irq_req_o = flag_reg & irq_en_reg & gie_reg;  // RULE10
  assign wake_o    = sleep_i & flag_reg & wake_en_reg;  // RULE12

  // Event status and mask
  assign ev = {dip_long, core_halt_o, det_set};

  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stat_reg <= `UVDR_EV_RST;
      mask_reg <= `UVDR_EV_RST;
    end
    else
    begin
      if (wr_i && addr_i == `UVDR_ADDR_STAT)
        stat_reg <= ev | (stat_reg & ~wdata_i[`UVDR_EV_W-1:0]);
      else
        stat_reg <= ev | stat_reg;
      if (wr_i && addr_i == `UVDR_ADDR_MASK)
        mask_reg <= wdata_i[`UVDR_EV_W-1:0];
    end
  end

  assign irq_o = |(stat_reg & mask_reg);

  // Read data, valid only the cycle after the strobe
  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      case (addr_i)
        `UVDR_ADDR_CTRL: rdata_o <= ctrl_val;
        `UVDR_ADDR_MASK: rdata_o <= {5'h00, mask_reg};
        `UVDR_ADDR_STAT: rdata_o <= {5'h00, stat_reg};
        default:         rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

endmodule // uvdr_low_voltage_detect_reset

// ### uvdr_chk_assertions.sv
/*
  Port checker for the undervoltage block.
  Assumes it is bound onto the design top and sees only its ports.
*/
`include "uvdr_defs.vh"
module uvdr_chk #(
  parameter DIP_CYC     = 20,
  parameter SYS_RST_CYC = 16
) (
  input logic       core_clk_i,             // Clock
  input logic       nrst_i,                 // Reset
  input logic       sleep_i,                // Sleep
  input logic       global_irq_on_instr_i,  // Global on
  input logic       global_irq_off_instr_i, // Global off
  input logic [1:0] addr_i,                 // Address
  input logic [7:0] wdata_i,                // Write data
  input logic       wr_i,                   // Write
  input logic       rd_i,                   // Read
  input logic [7:0] rdata_o,                // Read data
  input logic       irq_req_o,              // Core irq
  input logic       wake_o,                 // Wake
  input logic       core_halt_o,            // Halt
  input logic       sys_rst_n_o,            // System reset
  input logic       irq_o                   // Event irq
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  int hcnt;
  // Consecutive halt cycles
  always @(posedge core_clk_i or negedge nrst_i)
    if (!nrst_i)
      hcnt <= 0;
    else
      hcnt <= core_halt_o ? hcnt + 1 : 0;
  a_halt_bounded: assert property (hcnt <= DIP_CYC + 1)
    else $error("halt lasted past the dip limit");
  a_rst_held: assert property ($fell(sys_rst_n_o) |=> !sys_rst_n_o [*8])
    else $error("system reset pulse too short");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_global_off: assert property (
    global_irq_off_instr_i && !global_irq_on_instr_i |=> !irq_req_o)
    else $error("irq request after global disable");
  a_irq_en_off: assert property (
    wr_i && addr_i == `UVDR_ADDR_CTRL && !wdata_i[4] |=> !irq_req_o)
    else $error("irq request with enable clear");
  a_wake_en_off: assert property (
    wr_i && addr_i == `UVDR_ADDR_CTRL && !wdata_i[3] |=> !wake_o)
    else $error("wake with wake enable clear");
  a_wake_sleep: assert property (wake_o |-> sleep_i)
    else $error("wake outside sleep");
  a_mask_off: assert property (
    wr_i && addr_i == `UVDR_ADDR_MASK && wdata_i[2:0] == 3'h0 |=> !irq_o)
    else $error("event irq with mask clear");
  a_det_off_ok: assert property (
    wr_i && addr_i == `UVDR_ADDR_CTRL && !wdata_i[2] ##1 !wr_i
    ##1 rd_i && addr_i == `UVDR_ADDR_CTRL |=> rdata_o[5])
    else $error("state bit low with detector off");
endmodule // uvdr_chk
bind uvdr_low_voltage_detect_reset uvdr_chk #(.DIP_CYC(DIP_CYC),
  .SYS_RST_CYC(SYS_RST_CYC)) i_uvdr_chk (.*);

// ### uvdr_low_voltage_detect_reset_test.sv
/*
  Self-checking bench for the undervoltage block.
  Assumes the checker binds itself; comparators are driven directly.
*/
`include "uvdr_defs.vh"
module uvdr_low_voltage_detect_reset_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, nrst = 0, slp = 0, gon = 0, goff = 0;
  logic       wr = 0, rd = 0, m_flag = 0;
  logic [1:0] opt = 2'h3, addr = 2'h0;
  logic [3:0] det = 4'h0;
  logic [2:0] rcmp = 3'h0;
  logic [4:0] m_en = 5'h03;
  logic [7:0] wdata = 8'h00, rdata;
  logic       irq_req, wake, halt, srst_n, irq;
  int         num_errors = 0, total_checks = 0, r;
  always #10 clk = ~clk;
  uvdr_low_voltage_detect_reset #(.DIP_CYC(20))
    i_uvdr_low_voltage_detect_reset (.core_clk_i(clk), .nrst_i(nrst),
    .brownout_opt_i(opt), .det_cmp_i(det), .rst_cmp_i(rcmp),
    .sleep_i(slp), .global_irq_on_instr_i(gon),
    .global_irq_off_instr_i(goff), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_req_o(irq_req),
    .wake_o(wake), .core_halt_o(halt), .sys_rst_n_o(srst_n), .irq_o(irq));
  task automatic final_report();
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Model: writable bits, clear on bit 6 low
  task automatic wr_ctrl(input logic [7:0] d);
    wr_reg(`UVDR_ADDR_CTRL, d);
    m_en = d[4:0];
    if (!d[6])
      m_flag = 1'b0;
  endtask
  task automatic settle(input logic [3:0] d);
    @(posedge clk);
    det <= d;
    repeat (8) @(posedge clk);
    if (m_en[2] & d[m_en[1:0]])
      m_flag = 1'b1;
  endtask
  function automatic logic [7:0] ctrl_exp();
    ctrl_exp = {1'b0, m_flag, ~(m_en[2] & det[m_en[1:0]]), m_en};
  endfunction
  initial
  begin
    r = $urandom(32'hec9a);
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    wr_reg(2'h3, 8'hff);
    chk_rd(`UVDR_ADDR_CTRL, 8'h23);
    chk_rd(2'h3, 8'h00);
    rcmp <= 3'h7;
    repeat (30) @(posedge clk);
    #1 chk(halt, 1'b0);
    chk(srst_n, 1'b1);
    rcmp <= 3'h0;
    for (int l = 0; l < 4; l++)
    begin
      wr_ctrl(8'(l) | 8'h04 | (8'($urandom) & 8'h18));
      settle(4'($urandom) | 4'(1 << l));
      chk_rd(`UVDR_ADDR_CTRL, ctrl_exp());
      settle(4'($urandom) & ~4'(1 << l));
      chk_rd(`UVDR_ADDR_CTRL, ctrl_exp());
      wr_ctrl({3'h0, m_en});
      chk_rd(`UVDR_ADDR_CTRL, ctrl_exp());
    end
    wr_ctrl(8'h03);
    chk_rd(`UVDR_ADDR_CTRL, ctrl_exp());
    settle(4'hf);
    chk_rd(`UVDR_ADDR_CTRL, 8'h23);
    wr_ctrl(8'h1f);
    settle(4'h8);
    gon <= 1'b1;
    @(posedge clk);
    gon <= 1'b0;
    #1 chk(irq_req, 1'b1);
    @(posedge clk);
    goff <= 1'b1;
    slp <= 1'b1;
    @(posedge clk);
    goff <= 1'b0;
    #1 chk(irq_req, 1'b0);
    chk(wake, 1'b1);
    settle(4'h0);
    wr_ctrl(8'h1f);
    settle(4'h8);
    chk(wake, 1'b1);
    wr_ctrl(8'h57);
    #1 chk(wake, 1'b0);
    settle(4'h0);
    slp <= 1'b0;
    wr_reg(`UVDR_ADDR_MASK, 8'h01);
    #1 chk(irq, 1'b1);
    chk_rd(`UVDR_ADDR_STAT, 8'h01);
    wr_reg(`UVDR_ADDR_STAT, 8'h01);
    #1 chk(irq, 1'b0);
    wr_reg(`UVDR_ADDR_MASK, 8'h00);
    nrst <= 1'b0;
    opt <= 2'h2;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    m_flag = 1'b0;
    wr_ctrl(8'h16);
    rcmp <= 3'h1;
    repeat (10) @(posedge clk);
    #1 chk(halt, 1'b1);
    chk(srst_n, 1'b1);
    @(posedge clk);
    rcmp <= 3'h0;
    repeat (8) @(posedge clk);
    chk_rd(`UVDR_ADDR_CTRL, ctrl_exp());
    settle(4'h4);
    rcmp <= 3'h1;
    repeat (40) @(posedge clk);
    #1 chk(srst_n, 1'b0);
    @(posedge clk);
    rcmp <= 3'h0;
    repeat (40) @(posedge clk);
    m_en = 5'h03;
    m_flag = 1'b0;
    chk_rd(`UVDR_ADDR_CTRL, ctrl_exp());
    chk_rd(`UVDR_ADDR_STAT, 8'h07);
    final_report();
  end
  initial
  begin
    #200000;
    num_errors++;
    final_report();
  end
endmodule // uvdr_low_voltage_detect_reset_test
